// ---- srcg_record_ctrl.sv ----
// Host record writer and checker for soft-sectored diskette data blocks
`timescale 1ns/10ps
`default_nettype none
`include "srcg_consts.svh"

module srcg_record_ctrl
  import srcg_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire logic                     clkEn,
  input  wire logic                     bitTick,
  input  wire logic                     startWrite,
  input  wire logic                     startRead,
  input  wire logic                     doubleDensity,
  input  wire logic                     nineSector,
  input  wire logic [`SRCG_TRACK_W-1:0] trackNum,
  input  wire logic                     headSide,
  input  wire logic                     deletedMark,
  input  wire logic [7:0]               wrData,
  input  wire logic                     wrValid,
  input  wire logic                     wrFlush,
  output logic                          wrReady,
  input  wire logic                     rdBit,
  output logic                          wrGate,
  output logic                          wrBit,
  output logic                          wrClkMask,
  output logic                          encodingMfm,
  output logic [7:0]                    rdByte,
  output logic                          rdByteValid,
  output logic                          busy,
  output logic                          recDone,
  output logic                          crcOk,
  output logic                          deletedSeen,
  output logic                          markBad,
  output logic                          underrun
);

  // ==========================================
  // Declarations
  srcg_core_if cif ();

  srcg_state_type state_q;
  srcg_count_type cnt_q;
  srcg_count_type fieldSize_q;
  srcg_count_type fieldLast;
  srcg_count_type readLast;
  srcg_count_type preLast;
  logic           mfm_q;
  logic           deleted_q;
  logic           flush_q;
  logic           tick;
  logic           done;
  logic           take;
  logic           ldEn;
  logic [7:0]     ldByte;
  logic [7:0]     ldMask;
  logic           preset;
  logic [7:0]     markByte;
  logic [7:0]     markMask;
  logic [7:0]     dataByte;
  logic           writing;
  logic           crcActive;
  logic           startAny;
  logic           wrGate_q;
  logic           wrBit_q;
  logic           wrClkMask_q;
  logic [7:0]     rdByte_q;
  logic           rdByteValid_q;
  logic           recDone_q;
  logic           crcOk_q;
  logic           deletedSeen_q;
  logic           markBad_q;
  logic           underrun_q;

  // ==========================================
  // Submodules
  srcg_bit_shifter u_shifter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .sif     (cif.shf)
  );

  srcg_check_reg u_check (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cif     (cif.crc)
  );

  // ==========================================
  // Timing and derived sizes
  // One bit cell per tick; a low enable freezes everything
  assign tick      = clkEn & bitTick;
  assign done      = cif.shDone;
  assign startAny  = (state_q == ST_IDLE) & (startWrite | startRead);
  assign fieldLast = 9'(fieldSize_q - 9'h001);
  assign readLast  = 9'(fieldSize_q + `SRCG_CHECK_BYTES);
  assign preLast   = mfm_q ? 9'(`SRCG_MFM_PRE_BYTES - 9'h001)
                           : 9'(`SRCG_FM_PRE_BYTES - 9'h001);
  assign writing   = (state_q == ST_PRE) | (state_q == ST_SYNC) |
                     (state_q == ST_MARK) | (state_q == ST_DATA) |
                     (state_q == ST_CHECK) | (state_q == ST_GAP);
  assign crcActive = (state_q == ST_MARK) | (state_q == ST_DATA) |
                     (state_q == ST_CHECK) | (state_q == ST_READ);

  // Mark byte and its clock suppression mask
  assign markByte = deleted_q ? `SRCG_MARK_DELETED : `SRCG_MARK_NORMAL;
  assign markMask = mfm_q ? `SRCG_NO_MASK : ~`SRCG_FM_MARK_CLOCK;

  // Missing payload bytes go out as zero so the field keeps its length
  assign dataByte = wrValid ? wrData : `SRCG_PAD_BYTE;

  // ==========================================
  // Shifter and check register steering
  assign cif.ce         = clkEn;
  assign cif.shTick     = tick & (writing | (state_q == ST_READ)) & (state_q != ST_CHECK);
  assign cif.shLoad     = ldEn;
  assign cif.shByte     = ldByte;
  assign cif.shMask     = ldMask;
  assign cif.shSerIn    = (state_q == ST_READ) & rdBit;
  assign cif.crcTick    = tick & crcActive;
  assign cif.crcPreset  = preset;
  assign cif.crcInhibit = (state_q == ST_CHECK);
  assign cif.crcBit     = (state_q == ST_READ) ? rdBit : cif.shOut;

  // Byte handshake towards the payload source
  assign wrReady = take & wrValid;

  // ==========================================
  // Next byte selection for the shifter
  always_comb begin
    ldEn   = 1'b0;
    ldByte = `SRCG_PRE_BYTE;
    ldMask = `SRCG_NO_MASK;
    take   = 1'b0;
    preset = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (startWrite) begin
          ldEn = 1'b1;
        end else if (startRead) begin
          ldEn   = 1'b1;
          preset = 1'b1;
        end
      end
      ST_PRE: begin
        if (done) begin
          ldEn = 1'b1;
          if (cnt_q == preLast) begin
            if (mfm_q) begin
              ldByte = `SRCG_MFM_SYNC_BYTE;
              ldMask = `SRCG_MFM_SYNC_MASK;
            end else begin
              ldByte = markByte;
              ldMask = markMask;
              preset = 1'b1;
            end
          end
        end
      end
      ST_SYNC: begin
        if (done) begin
          ldEn = 1'b1;
          if (cnt_q == 9'(`SRCG_MFM_SYNC_COUNT - 9'h001)) begin
            ldByte = markByte;
            ldMask = markMask;
            preset = 1'b1;
          end else begin
            ldByte = `SRCG_MFM_SYNC_BYTE;
            ldMask = `SRCG_MFM_SYNC_MASK;
          end
        end
      end
      ST_MARK: begin
        if (done) begin
          ldEn   = 1'b1;
          take   = 1'b1;
          ldByte = dataByte;
        end
      end
      ST_DATA: begin
        if (done && cnt_q != fieldLast) begin
          ldEn   = 1'b1;
          take   = 1'b1;
          ldByte = dataByte;
        end
      end
      ST_CHECK: begin
        if (tick && mfm_q && cnt_q == 9'(`SRCG_CHECK_BITS - 9'h001)) begin
          ldEn   = 1'b1;
          ldByte = `SRCG_MFM_GAP_BYTE;
        end
      end
      ST_GAP: begin
        if (done && cnt_q != 9'(`SRCG_MFM_GAP_COUNT - 9'h001)) begin
          ldEn   = 1'b1;
          ldByte = `SRCG_MFM_GAP_BYTE;
        end
      end
      default: begin
        ldEn = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Sequencer and its byte or bit counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cnt_q   <= 9'h000;
    end else if (clkEn) begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 9'h000;
          if (startWrite) begin
            state_q <= ST_PRE;
          end else if (startRead) begin
            state_q <= ST_READ;
          end
        end
        ST_PRE: begin
          if (done) begin
            if (cnt_q == preLast) begin
              state_q <= mfm_q ? ST_SYNC : ST_MARK;
              cnt_q   <= 9'h000;
            end else begin
              cnt_q <= srcg_inc(cnt_q);
            end
          end
        end
        ST_SYNC: begin
          if (done) begin
            if (cnt_q == 9'(`SRCG_MFM_SYNC_COUNT - 9'h001)) begin
              state_q <= ST_MARK;
              cnt_q   <= 9'h000;
            end else begin
              cnt_q <= srcg_inc(cnt_q);
            end
          end
        end
        ST_MARK: begin
          if (done) begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (done) begin
            if (cnt_q == fieldLast) begin
              state_q <= ST_CHECK;
              cnt_q   <= 9'h000;
            end else begin
              cnt_q <= srcg_inc(cnt_q);
            end
          end
        end
        ST_CHECK: begin
          if (tick) begin
            if (cnt_q == 9'(`SRCG_CHECK_BITS - 9'h001)) begin
              state_q <= mfm_q ? ST_GAP : ST_DONE;
              cnt_q   <= 9'h000;
            end else begin
              cnt_q <= srcg_inc(cnt_q);
            end
          end
        end
        ST_GAP: begin
          if (done) begin
            if (cnt_q == 9'(`SRCG_MFM_GAP_COUNT - 9'h001)) begin
              state_q <= ST_DONE;
            end else begin
              cnt_q <= srcg_inc(cnt_q);
            end
          end
        end
        ST_READ: begin
          if (done) begin
            if (cnt_q == readLast) begin
              state_q <= ST_DONE;
            end else begin
              cnt_q <= srcg_inc(cnt_q);
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Record format, caught at start and held for the whole record
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mfm_q       <= 1'b0;
      fieldSize_q <= `SRCG_FM_FIELD;
      deleted_q   <= 1'b0;
    end else if (clkEn && startAny) begin
      mfm_q       <= srcg_use_mfm(doubleDensity, trackNum, headSide);
      fieldSize_q <= srcg_field_size(srcg_use_mfm(doubleDensity, trackNum, headSide),
                                     nineSector);
      deleted_q   <= deletedMark;
    end
  end

  // ==========================================
  // Write channel: one bit cell per tick, check bits straight from stage 15
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrGate_q    <= 1'b0;
      wrBit_q     <= 1'b0;
      wrClkMask_q <= 1'b0;
    end else if (clkEn) begin
      wrGate_q <= writing;
      if (tick && writing) begin
        wrBit_q     <= (state_q == ST_CHECK) ? cif.crcVal[15] : cif.shOut;
        wrClkMask_q <= (state_q == ST_CHECK) ? 1'b0 : cif.shMaskOut;
      end else if (!writing) begin
        wrBit_q     <= 1'b0;
        wrClkMask_q <= 1'b0;
      end
    end
  end

  // Padding request is sticky; a request arriving with the start still counts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flush_q    <= 1'b0;
      underrun_q <= 1'b0;
    end else if (clkEn) begin
      flush_q <= startAny ? wrFlush : (flush_q | wrFlush);
      if (startAny) begin
        underrun_q <= 1'b0;
      end else if (take && !wrValid && !flush_q && !wrFlush) begin
        underrun_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // Read results; the remainder is judged after the last check bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdByte_q      <= 8'h00;
      rdByteValid_q <= 1'b0;
      recDone_q     <= 1'b0;
      crcOk_q       <= 1'b0;
      deletedSeen_q <= 1'b0;
      markBad_q     <= 1'b0;
    end else if (clkEn) begin
      rdByteValid_q <= 1'b0;
      recDone_q     <= (state_q == ST_DONE);
      if (startAny) begin
        crcOk_q       <= 1'b0;
        deletedSeen_q <= 1'b0;
        markBad_q     <= 1'b0;
      end
      if (state_q == ST_READ && done) begin
        rdByte_q      <= cif.shCap;
        rdByteValid_q <= 1'b1;
        if (cnt_q == 9'h000) begin
          deletedSeen_q <= (cif.shCap == `SRCG_MARK_DELETED);
          markBad_q     <= (cif.shCap != `SRCG_MARK_DELETED) &&
                           (cif.shCap != `SRCG_MARK_NORMAL);
        end
      end
      if (state_q == ST_DONE && !wrGate_q) begin
        crcOk_q <= (cif.crcVal == `SRCG_CRC_ZERO);
      end
    end
  end

  // ==========================================
  // Outputs
  assign wrGate      = wrGate_q;
  assign wrBit       = wrBit_q;
  assign wrClkMask   = wrClkMask_q;
  assign encodingMfm = mfm_q;
  assign rdByte      = rdByte_q;
  assign rdByteValid = rdByteValid_q;
  assign busy        = (state_q != ST_IDLE);
  assign recDone     = recDone_q;
  assign crcOk       = crcOk_q;
  assign deletedSeen = deletedSeen_q;
  assign markBad     = markBad_q;
  assign underrun    = underrun_q;

endmodule : srcg_record_ctrl

`default_nettype wire

// ---- srcg_consts.svh ----
// Constants for the sector record check generator
`ifndef SRCG_CONSTS_SVH
`define SRCG_CONSTS_SVH

// ==========================================
// Check register
`define SRCG_CRC_PRESET 16'hFFFF
`define SRCG_CRC_ZERO 16'h0000
`define SRCG_CHECK_BITS 9'h010

// ==========================================
// Field sizes in bytes
`define SRCG_FM_FIELD 9'h080
`define SRCG_WIDE_FIELD 9'h100
`define SRCG_CHECK_BYTES 9'h002

// ==========================================
// Mark bytes and clock patterns
`define SRCG_MARK_NORMAL 8'hFB
`define SRCG_MARK_DELETED 8'hF8
`define SRCG_FM_MARK_CLOCK 8'hC7
`define SRCG_FM_PRE_BYTES 9'h006
`define SRCG_MFM_PRE_BYTES 9'h00C
`define SRCG_PRE_BYTE 8'h00
`define SRCG_PAD_BYTE 8'h00
`define SRCG_MFM_SYNC_BYTE 8'hA1
`define SRCG_MFM_SYNC_MASK 8'h04
`define SRCG_MFM_SYNC_COUNT 9'h003
`define SRCG_MFM_GAP_BYTE 8'h4E
`define SRCG_MFM_GAP_COUNT 9'h036
`define SRCG_NO_MASK 8'h00

// ==========================================
// Widths
`define SRCG_TRACK_W 7

`endif

// ---- srcg_pkg.sv ----
// Types and helper functions for the sector record check generator
`default_nettype none
`include "srcg_consts.svh"

package srcg_pkg;

  // ==========================================
  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_PRE   = 4'h1,
    ST_SYNC  = 4'h2,
    ST_MARK  = 4'h3,
    ST_DATA  = 4'h4,
    ST_CHECK = 4'h5,
    ST_GAP   = 4'h6,
    ST_READ  = 4'h7,
    ST_DONE  = 4'h8
  } srcg_state_type;

  typedef logic [8:0] srcg_count_type;

  // ==========================================
  // Helpers
  // Track 0 side 0 stays FM even on double density media
  function automatic logic srcg_use_mfm(input logic dd,
                                        input logic [`SRCG_TRACK_W-1:0] trk,
                                        input logic side);
    return dd & ~((trk == '0) & ~side);
  endfunction : srcg_use_mfm

  function automatic srcg_count_type srcg_field_size(input logic mfm, input logic nine);
    return (mfm | nine) ? `SRCG_WIDE_FIELD : `SRCG_FM_FIELD;
  endfunction : srcg_field_size

  function automatic srcg_count_type srcg_inc(input srcg_count_type c);
    return 9'(c + 9'h001);
  endfunction : srcg_inc

endpackage : srcg_pkg

`default_nettype wire

// ---- srcg_core_if.sv ----
// Internal carrier between controller, bit shifter and check register
`timescale 1ns/10ps
`default_nettype none

interface srcg_core_if;
  logic        ce;
  logic        shTick;
  logic        shLoad;
  logic        shSerIn;
  logic [7:0]  shByte;
  logic [7:0]  shMask;
  logic        shOut;
  logic        shMaskOut;
  logic        shDone;
  logic [7:0]  shCap;
  logic        crcTick;
  logic        crcPreset;
  logic        crcInhibit;
  logic        crcBit;
  logic [15:0] crcVal;

  modport ctrl (output ce, shTick, shLoad, shSerIn, shByte, shMask,
                output crcTick, crcPreset, crcInhibit, crcBit,
                input shOut, shMaskOut, shDone, shCap, crcVal);
  modport shf (input ce, shTick, shLoad, shSerIn, shByte, shMask,
               output shOut, shMaskOut, shDone, shCap);
  modport crc (input ce, crcTick, crcPreset, crcInhibit, crcBit,
               output crcVal);
endinterface : srcg_core_if

`default_nettype wire

// ---- srcg_check_reg.sv ----
// Sixteen stage serial record check register
`timescale 1ns/10ps
`default_nettype none

module srcg_check_reg
  import srcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  srcg_core_if.crc cif
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic        feedback;

  // ==========================================
  // Feedback network; inhibit turns it into a plain shifter
  always_comb begin
    feedback = cif.crcInhibit ? 1'b0 : (cif.crcBit ^ crc_q[15]);
    crc_d = {crc_q[14:12], crc_q[11] ^ feedback, crc_q[10:5],
             crc_q[4] ^ feedback, crc_q[3:0], feedback};
  end

  // Preset beats a shift so a record always starts from all ones
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      crc_q <= `SRCG_CRC_PRESET;
    end else if (cif.ce) begin
      if (cif.crcPreset) begin
        crc_q <= `SRCG_CRC_PRESET;
      end else if (cif.crcTick) begin
        crc_q <= crc_d;
      end
    end
  end

  assign cif.crcVal = crc_q;

endmodule : srcg_check_reg

`default_nettype wire

// ---- srcg_bit_shifter.sv ----
// Byte to bit serialiser and bit to byte collector, MSB first
`timescale 1ns/10ps
`default_nettype none

module srcg_bit_shifter
  import srcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  srcg_core_if.shf sif
);

  logic [7:0] data_q;
  logic [7:0] mask_q;
  logic [2:0] bit_q;

  // ==========================================
  // Outputs; done fires on the tick that moves the eighth bit
  assign sif.shOut     = data_q[7];
  assign sif.shMaskOut = mask_q[7];
  assign sif.shDone    = sif.shTick & (bit_q == 3'h7);
  assign sif.shCap     = {data_q[6:0], sif.shSerIn};

  // Load wins over a tick so the next byte follows without a gap
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_q <= 8'h00;
      mask_q <= 8'h00;
      bit_q  <= 3'h0;
    end else if (sif.ce) begin
      if (sif.shLoad) begin
        data_q <= sif.shByte;
        mask_q <= sif.shMask;
        bit_q  <= 3'h0;
      end else if (sif.shTick) begin
        data_q <= {data_q[6:0], sif.shSerIn};
        mask_q <= {mask_q[6:0], 1'b0};
        bit_q  <= 3'(bit_q + 3'h1);
      end
    end
  end

endmodule : srcg_bit_shifter

`default_nettype wire

// ---- srcg_props.sv ----
// Port checker for the sector record controller
`timescale 1ns/10ps
`default_nettype none
`include "srcg_consts.svh"

module srcg_props
  import srcg_pkg::*;
(
  input wire logic                     ref_clk,
  input wire logic                     reset,
  input wire logic                     clkEn,
  input wire logic                     bitTick,
  input wire logic                     startWrite,
  input wire logic                     doubleDensity,
  input wire logic [`SRCG_TRACK_W-1:0] trackNum,
  input wire logic                     headSide,
  input wire logic                     wrValid,
  input wire logic                     wrReady,
  input wire logic                     wrGate,
  input wire logic                     wrBit,
  input wire logic                     encodingMfm,
  input wire logic                     rdByteValid,
  input wire logic                     busy,
  input wire logic                     recDone,
  input wire logic                     crcOk,
  input wire logic                     underrun
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================
  // Start, gate and completion timing
  a_start_busy: assert property (!busy && clkEn && startWrite |=> busy)
    else $error("write start not taken");
  a_gate_rise: assert property (!busy && clkEn && startWrite |-> ##2 wrGate)
    else $error("write gate late");
  a_done_pulse: assert property (recDone |=> !recDone)
    else $error("done longer than one cycle");
  a_done_idle: assert property (recDone |-> !busy)
    else $error("done while busy");
  // Cells only move on bit ticks, so the serial order cannot slip
  a_bit_hold: assert property (wrGate && $past(wrGate) && $changed(wrBit) |-> $past(bitTick))
    else $error("cell changed off tick");
  a_ready_valid: assert property (wrReady |-> wrValid && busy)
    else $error("byte taken without offer");
  // Density choice follows track and side at the start cycle
  a_track_enc: assert property (!busy && clkEn && startWrite |=>
      encodingMfm == $past(doubleDensity && !(trackNum == '0 && !headSide)))
    else $error("wrong encoding chosen");
  a_ok_done: assert property ($rose(crcOk) |-> recDone)
    else $error("check pass outside completion");
  a_read_nogate: assert property (rdByteValid |-> !wrGate)
    else $error("read byte during write");
  a_under_write: assert property ($rose(underrun) |-> wrGate)
    else $error("underrun outside write");
endmodule : srcg_props

bind srcg_record_ctrl srcg_props chk_u (.ref_clk, .reset, .clkEn, .bitTick, .startWrite, .doubleDensity,
  .trackNum, .headSide, .wrValid, .wrReady, .wrGate, .wrBit, .encodingMfm, .rdByteValid, .busy,
  .recDone, .crcOk, .underrun);

`default_nettype wire

// ---- srcg_drive_model.sv ----
// Behavioural drive data channel that records written cells and replays them
`timescale 1ns/10ps
`default_nettype none

module srcg_drive_model (
  input wire logic        ref_clk,
  input wire logic        bitTick,
  input wire logic        wrGate,
  input wire logic        wrBit,
  input wire logic        rdLoad,
  input wire logic [11:0] rdFrom,
  input wire logic [11:0] flipAt,
  output logic            rdBit
);
  logic        mem [0:4095];
  logic [11:0] wrIdx = '0;
  logic [11:0] rdIdx = '0;
  logic        tickD = 1'b0;
  logic        gateD = 1'b0;

  // ==========================================
  // Record the cell launched by the previous tick, replay from a given cell
  always @(posedge ref_clk) begin
    tickD <= bitTick;
    gateD <= wrGate;
    if (wrGate && !gateD) wrIdx <= '0;
    else if (wrGate && tickD) begin
      mem[wrIdx] <= wrBit;
      wrIdx <= wrIdx + 12'h001;
    end
    if (rdLoad) rdIdx <= rdFrom;
    else if (bitTick) rdIdx <= rdIdx + 12'h001;
  end
  // Past the recording the head sees noise, modelled as a toggling cell
  assign rdBit = (rdIdx < wrIdx) ? mem[rdIdx] ^ (rdIdx == flipAt) : rdIdx[0];
endmodule : srcg_drive_model

`default_nettype wire

// ---- sector_record_check_generator_test.sv ----
// Self-checking bench for the sector record controller
`timescale 1ns/10ps
`default_nettype none
`include "srcg_consts.svh"

module sector_record_check_generator_test;
  import srcg_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1, bitTick = 1'b0, startWrite = 1'b0, startRead = 1'b0;
  logic        dd = 1'b0, nine = 1'b0, side = 1'b0, del = 1'b0, fl = 1'b0, rdLoad = 1'b0;
  logic        wrValid = 1'b0, wrFlush = 1'b0, clkEn = 1'b1;
  logic [6:0]  trk = '0;
  logic [7:0]  wrData = '0;
  logic [11:0] rdFrom = '0, flipAt = 12'hFFF;
  logic        rdBit, wrReady, wrGate, wrBit, wrClkMask, encodingMfm, rdByteValid;
  logic        busy, recDone, crcOk, deletedSeen, markBad, underrun;
  logic [7:0]  rdByte, dB, mB, rec [0:258];
  logic [15:0] expQ [$];
  int          err_total = 0, total_checks = 0, cyc = 0, nBit = 0, recLen = 0, k = 0, nVal = 0, tc = 0;
  int          seed = 32'h79500F60;

  srcg_record_ctrl dut_u (.ref_clk, .reset, .clkEn, .bitTick, .startWrite, .startRead,
    .doubleDensity(dd), .nineSector(nine), .trackNum(trk), .headSide(side), .deletedMark(del), .wrData,
    .wrValid, .wrFlush, .wrReady, .rdBit, .wrGate, .wrBit, .wrClkMask, .encodingMfm, .rdByte,
    .rdByteValid, .busy, .recDone, .crcOk, .deletedSeen, .markBad, .underrun);
  srcg_drive_model drv_u (.ref_clk, .bitTick, .wrGate, .wrBit, .rdLoad, .rdFrom, .flipAt, .rdBit);

  // ==========================================
  // Clock, one bit cell every four cycles, hang guard
  always #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    tc = (tc + 1) % 4;
    bitTick <= (tc == 0);
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      final_report();
    end
  end

  // Payload offer; flush only once the short payload is used up
  always @(posedge ref_clk) if (wrReady) k <= k + 1;
  always @(negedge ref_clk) begin
    wrValid <= (k < nVal);
    wrData <= rec[k + 1];
    wrFlush <= fl && (k >= nVal);
  end

  // Assemble written cells and read bytes, compare with the oldest note
  always @(negedge ref_clk) begin
    if (!wrGate) nBit = 0;
    else if (bitTick) begin
      dB = {dB[6:0], wrBit};
      mB = {mB[6:0], wrClkMask};
      nBit++;
      if (nBit % 8 == 0) cmp({mB, dB});
    end
    if (rdByteValid) cmp({8'h00, rdByte});
  end

  // ==========================================
  // Comparison helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cmp(input logic [15:0] g);
    chk(g, expQ.size() ? expQ.pop_front() : 16'hFFFF);
  endtask : cmp

  // Start right after a tick so the first cell lands after the gate rises
  task automatic go(input logic w);
    @(negedge ref_clk iff bitTick);
    startWrite <= w;
    startRead <= !w;
    rdLoad <= !w;
    @(negedge ref_clk);
    startWrite <= 1'b0;
    startRead <= 1'b0;
    rdLoad <= 1'b0;
    for (int i = 0; i < 20000 && recDone !== 1'b1; i++) @(negedge ref_clk);
  endtask : go

  // Write one record and note the full expected cell stream
  task automatic wr(input logic d, n9, sd, dl, input logic [6:0] t, input int nv, input logic f);
    logic [15:0] c;
    logic        m;
    int          n;
    dd = d;
    nine = n9;
    side = sd;
    del = dl;
    trk = t;
    nVal = nv;
    fl = f;
    k = 0;
    m = d && !(t == '0 && !sd);
    n = (m || n9) ? `SRCG_WIDE_FIELD : `SRCG_FM_FIELD;
    rec[0] = dl ? `SRCG_MARK_DELETED : `SRCG_MARK_NORMAL;
    c = 16'hFFFF;
    for (int i = 1; i <= n; i++) rec[i] = (i <= nv) ? 8'($random(seed)) : 8'h00;
    for (int i = 0; i <= n; i++)
      for (int j = 7; j >= 0; j--) c = {c[14:0], 1'b0} ^ ((rec[i][j] ^ c[15]) ? 16'h1021 : 16'h0000);
    rec[n + 1] = c[15:8];
    rec[n + 2] = c[7:0];
    recLen = n + 3;
    for (int i = 0; i < (m ? 12 : 6); i++) expQ.push_back(16'h0000);
    for (int i = 0; i < (m ? 3 : 0); i++) expQ.push_back(16'h04A1);
    expQ.push_back({m ? 8'h00 : 8'h38, rec[0]});
    for (int i = 1; i < recLen; i++) expQ.push_back({8'h00, rec[i]});
    for (int i = 0; i < (m ? 54 : 0); i++) expQ.push_back(16'h004E);
    go(1'b1);
    chk(encodingMfm, m);
    chk(underrun, nv < n && !f);
    chk(16'(expQ.size()), 16'h0000);
    @(negedge ref_clk);
  endtask : wr

  // Read back from the mark cell, optionally with one cell flipped
  task automatic rd(input int off, input int p);
    flipAt = (p < 0) ? 12'hFFF : 12'(off + p);
    rdFrom = 12'(off);
    for (int i = 0; i < recLen; i++)
      expQ.push_back({8'h00, rec[i] ^ ((p >= 0 && p / 8 == i) ? 8'h80 >> (p % 8) : 8'h00)});
    go(1'b0);
    chk(crcOk, p < 0);
    chk(deletedSeen, rec[0] == 8'hF8);
    chk(markBad, p >= 0 && p < 8);
    chk(16'(expQ.size()), 16'h0000);
    @(negedge ref_clk);
  endtask : rd

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(negedge ref_clk);
    reset <= 1'b0;
    chk({busy, wrGate, recDone, crcOk, underrun, markBad}, 16'h0000);
    // A start offered while the enable is low must leave the controller idle
    clkEn <= 1'b0;
    startWrite <= 1'b1;
    repeat (3) @(negedge ref_clk);
    startWrite <= 1'b0;
    clkEn <= 1'b1;
    chk({busy, wrGate}, 16'h0000);
    $display("test frozen start ended");
    wr(1'b1, 1'b0, 1'b0, 1'b0, 7'h00, 10, 1'b1);
    $display("test single density padded write ended");
    rd(48, -1);
    $display("test single density read ended");
    rd(48, 1);
    $display("test corrupted mark read ended");
    wr(1'b1, 1'b0, 1'b0, 1'b1, 7'h05, 256, 1'b0);
    $display("test double density deleted write ended");
    rd(120, -1);
    $display("test double density read ended");
    wr(1'b0, 1'b1, 1'b1, 1'b0, 7'h00, 0, 1'b0);
    $display("test nine sector underrun write ended");
    final_report();
  end
endmodule : sector_record_check_generator_test

`default_nettype wire
